// ===== rtl/pss_pkg.sv
// Constants, types and state layout of the slot power sequencer
// ==========================================================================
// Function
// (RL1) The live 4-bit position counter is readable in the low nibble of sequence_position.
// (RL2) Each slot lasts the time picked by the 4-bit slot_length code, 32 us up to 8.192 ms.
// (RL3) Slots with no regulator assigned last the empty_slot_wait time, with the same code table.
// (RL4) Each of the four linear regulators is switched when the sequence reaches its slot.
// (RL5) Each of the four switchers is switched when the position equals its slot.
// (RL6) Each general output goes active when the position reaches its assert slot.
// (RL7) Each general output goes inactive when the position reaches its de-assert slot.
// (RL8) The pull-down-disable function is applied at its programmed slot.
// (RL9) The 32 kHz clock to the outputs and the real-time counter is enabled at its slot.
// (RL10) The sequence holds at the wait slot as the wait setting asks.
// (RL11) The power-domain end lies between the system-domain end and the maximum slot.
// (RL12) The system-domain end lies between the standby stop slot and the power-domain end.
// (RL13) Going down into standby stops at the standby stop slot, which lies from 1 to the system end.
// (RL14) The maximum slot ends the power1 domain and tops the sequence, at or above the power end.
// (RL15) Direction code 01 holds when going up, 10 when going down, 11 both ways, 00 never.
// (RL16) The counter moves one slot per elapsed slot time, up or down, acting on what meets it.
// (RL17) Going up stops at the target domain end; going down never goes below the standby stop slot.
package pss_pkg;

  // ========================================================================
  // Timing
  localparam int CLK_NS = 40;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;

  // ========================================================================
  // Register map
  localparam int NREG = 16;
  localparam int RI_POS = 0;
  localparam int RI_TIM = 1;
  localparam int RI_LIN_A = 2;
  localparam int RI_LIN_B = 3;
  localparam int RI_PD = 4;
  localparam int RI_SW_A = 5;
  localparam int RI_SW_B = 6;
  localparam int RI_OUT0 = 7;
  localparam int RI_CLKH = 12;
  localparam int RI_DOM_A = 13;
  localparam int RI_DOM_B = 14;
  localparam int RI_WAIT = 15;
  localparam logic [NREG-1:0][7:0] REG_ADDR = {
    8'h97, 8'h96, 8'h95, 8'h92, 8'h91, 8'h90, 8'h8F, 8'h8E,
    8'h8D, 8'h8A, 8'h89, 8'h88, 8'h84, 8'h83, 8'h82, 8'h81};
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [3:0] RSVD_HI = 4'h0;

  // Field layout
  localparam int NW = 4;
  localparam int LO = 0;
  localparam int HI = 4;
  localparam logic LN = 1'b0;
  localparam logic HN = 1'b1;
  localparam int WDIR_LSB = 6;
  localparam int WDIR_W = 2;
  localparam int WDIR_UP = 0;
  localparam int WDIR_DN = 1;

  // Slot times in microseconds, indexed by code
  localparam logic [15:0][13:0] SLOT_US = {
    14'h2000, 14'h1000, 14'h0800, 14'h0400, 14'h0200, 14'h01C0, 14'h0180, 14'h0120,
    14'h0100, 14'h00E0, 14'h00C0, 14'h00A0, 14'h0080, 14'h0060, 14'h0040, 14'h0020};
  localparam logic [13:0] LAST_US = 14'h0001;

  // ========================================================================
  // Types
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RUN = 2'h1,
    SEQ_HOLD = 2'h3
  } pss_seq_e;

  typedef enum logic [1:0] {
    DOM_STANDBY = 2'h0,
    DOM_SYSTEM = 2'h1,
    DOM_POWER = 2'h2,
    DOM_POWER1 = 2'h3
  } pss_dom_e;

  typedef struct packed {
    logic [3:0] lin;
    logic [3:0] sw;
    logic [4:0] gpo;
    logic pulldown_disable;
    logic clk32;
  } pss_pwr_s;

  typedef struct packed {
    pss_seq_e state;
    logic [3:0] pos;
    logic [NREG-1:0][7:0] regs;
    logic [15:0] us_div;
    logic [13:0] slot_left;
    logic [1:0] sync;
    pss_pwr_s outs;
    logic [7:0] rdata;
    logic busy;
  } pss_state_s;

  localparam pss_state_s STATE_RST = '0;

endpackage

// ===== rtl/pss_seq.sv
// Slot power sequencer: position counter, slot timer, resource actions, registers
`timescale 1ns/1ps
module pss_seq #(
  parameter int US_CYC_P = pss_pkg::US_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Power mode request
  input wire logic [1:0] target_in,
  input wire logic wait_release_in,
  // Controlled resources
  output pss_pkg::pss_pwr_s power_out,
  output logic busy_out
);

  // ==========================================================================
  // State
  pss_pkg::pss_state_s q;
  pss_pkg::pss_state_s n;

  logic [3:0] lin_s [4];
  logic [3:0] sw_s [4];
  logic [3:0] oa [5];
  logic [3:0] od [5];
  logic [3:0] lin_hit;
  logic [3:0] sw_hit;
  logic [4:0] oa_hit;
  logic [4:0] od_hit;
  logic [3:0] slot_len;
  logic [3:0] empty_wait;
  logic [3:0] pd_slot;
  logic [3:0] clk_slot;
  logic [3:0] wait_slot;
  logic [3:0] sys_end;
  logic [3:0] pwr_end;
  logic [3:0] max_slot;
  logic [3:0] stop_slot;
  logic [1:0] wdir;
  logic [3:0] sel;
  logic [3:0] tgt;
  logic [3:0] np;
  logic up;
  logic tick;
  logic expire;
  logic hold;

  function automatic logic [3:0] nib(input logic [7:0] b, input logic h);
    return h ? b[pss_pkg::HI +: pss_pkg::NW] : b[pss_pkg::LO +: pss_pkg::NW];
  endfunction

  // ==========================================================================
  // Field decode
  genvar g;
  for (g = 0; g < 4; g++) begin : g_reg
    assign lin_s[g] = nib(q.regs[pss_pkg::RI_LIN_A + g / 2], g % 2 == 1);
    // Second switcher pair is stored high nibble first
    assign sw_s[g] = nib(q.regs[pss_pkg::RI_SW_A + g / 2], (g % 2 == 1) ^ (g / 2 == 1));
    assign lin_hit[g] = lin_s[g] == q.pos;
    assign sw_hit[g] = sw_s[g] == q.pos;
  end
  for (g = 0; g < 5; g++) begin : g_out
    assign oa[g] = nib(q.regs[pss_pkg::RI_OUT0 + g], pss_pkg::LN);
    assign od[g] = nib(q.regs[pss_pkg::RI_OUT0 + g], pss_pkg::HN);
    assign oa_hit[g] = oa[g] == q.pos;
    assign od_hit[g] = od[g] == q.pos;
  end

  assign slot_len = nib(q.regs[pss_pkg::RI_TIM], pss_pkg::LN);
  assign empty_wait = nib(q.regs[pss_pkg::RI_TIM], pss_pkg::HN);
  assign pd_slot = nib(q.regs[pss_pkg::RI_PD], pss_pkg::HN);
  assign clk_slot = nib(q.regs[pss_pkg::RI_CLKH], pss_pkg::HN);
  assign wait_slot = nib(q.regs[pss_pkg::RI_CLKH], pss_pkg::LN);
  assign sys_end = nib(q.regs[pss_pkg::RI_DOM_A], pss_pkg::LN);
  assign pwr_end = nib(q.regs[pss_pkg::RI_DOM_A], pss_pkg::HN);
  assign max_slot = nib(q.regs[pss_pkg::RI_DOM_B], pss_pkg::LN);
  assign stop_slot = nib(q.regs[pss_pkg::RI_DOM_B], pss_pkg::HN);
  assign wdir = q.regs[pss_pkg::RI_WAIT][pss_pkg::WDIR_LSB +: pss_pkg::WDIR_W];

  // ==========================================================================
  // Target and step
  // Bound ordering is software's job; only a target below the standby stop slot is raised to it
  always_comb begin
    unique case (pss_pkg::pss_dom_e'(target_in))
      pss_pkg::DOM_STANDBY: sel = stop_slot; // RL13
      pss_pkg::DOM_SYSTEM: sel = sys_end; // RL12
      pss_pkg::DOM_POWER: sel = pwr_end; // RL11
      pss_pkg::DOM_POWER1: sel = max_slot; // RL14
    endcase
  end

  assign tgt = (sel < stop_slot) ? stop_slot : sel; // RL17
  assign up = tgt > q.pos;
  assign np = up ? 4'(q.pos + 4'h1) : 4'(q.pos - 4'h1); // RL16
  assign tick = q.us_div == 16'(US_CYC_P - 1);
  assign expire = q.state == pss_pkg::SEQ_RUN && tick && q.slot_left == pss_pkg::LAST_US;
  assign hold = wait_slot == np && (up ? wdir[pss_pkg::WDIR_UP] : wdir[pss_pkg::WDIR_DN]); // RL15

  function automatic logic occ(input logic [3:0] p);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (lin_s[i] == p || sw_s[i] == p) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] dur(input logic [3:0] p);
    return occ(p) ? pss_pkg::SLOT_US[slot_len] : pss_pkg::SLOT_US[empty_wait]; // RL2 RL3
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    n = q;
    // Only the second stage reads the first
    n.sync = {q.sync[0], wait_release_in};

    n.rdata = pss_pkg::RD_NONE;
    for (int i = 0; i < pss_pkg::NREG; i++) begin
      if (reg_addr_in == pss_pkg::REG_ADDR[i]) begin
        n.rdata = (i == pss_pkg::RI_POS) ? {pss_pkg::RSVD_HI, q.pos} : q.regs[i]; // RL1
        if (reg_wr_in && i != pss_pkg::RI_POS) begin
          n.regs[i] = reg_wdata_in;
        end
      end
    end

    if (q.state == pss_pkg::SEQ_RUN) begin
      n.us_div = tick ? '0 : 16'(q.us_div + 16'h1);
      if (tick) begin
        n.slot_left = 14'(q.slot_left - pss_pkg::LAST_US);
      end
    end

    unique case (q.state)
      pss_pkg::SEQ_IDLE: begin
        if (tgt != q.pos) begin
          n.state = pss_pkg::SEQ_RUN;
          n.us_div = '0;
          n.slot_left = dur(q.pos);
        end
      end
      pss_pkg::SEQ_RUN: begin
        if (expire) begin
          if (tgt == q.pos) begin
            // Target moved onto us while the slot ran
            n.state = pss_pkg::SEQ_IDLE;
          end else begin
            n.pos = np; // RL16
            for (int i = 0; i < 4; i++) begin
              if (up && lin_s[i] == np) begin
                n.outs.lin[i] = 1'b1; // RL4
              end
              if (!up && lin_s[i] == q.pos) begin
                n.outs.lin[i] = 1'b0; // RL4
              end
              if (up && sw_s[i] == np) begin
                n.outs.sw[i] = 1'b1; // RL5
              end
              if (!up && sw_s[i] == q.pos) begin
                n.outs.sw[i] = 1'b0; // RL5
              end
            end
            for (int i = 0; i < 5; i++) begin
              if (oa[i] == np) begin
                n.outs.gpo[i] = 1'b1; // RL6
              end
              // De-assert wins if both slots coincide
              if (od[i] == np) begin
                n.outs.gpo[i] = 1'b0; // RL7
              end
            end
            if (up && pd_slot == np) begin
              n.outs.pulldown_disable = 1'b1; // RL8
            end
            if (!up && pd_slot == q.pos) begin
              n.outs.pulldown_disable = 1'b0; // RL8
            end
            if (up && clk_slot == np) begin
              n.outs.clk32 = 1'b1; // RL9
            end
            if (!up && clk_slot == q.pos) begin
              n.outs.clk32 = 1'b0; // RL9
            end
            if (hold) begin
              n.state = pss_pkg::SEQ_HOLD; // RL10
            end else if (np == tgt) begin
              n.state = pss_pkg::SEQ_IDLE; // RL17
            end else begin
              n.us_div = '0;
              n.slot_left = dur(np);
            end
          end
        end
      end
      pss_pkg::SEQ_HOLD: begin
        if (q.sync[1]) begin
          n.state = (tgt == q.pos) ? pss_pkg::SEQ_IDLE : pss_pkg::SEQ_RUN; // RL10
          n.us_div = '0;
          n.slot_left = dur(q.pos);
        end
      end
      default: n.state = pss_pkg::SEQ_IDLE;
    endcase

    n.busy = n.state != pss_pkg::SEQ_IDLE;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= pss_pkg::STATE_RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign power_out = q.outs;
  assign busy_out = q.busy;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  pos_read_a: assert property ( // RL1
    $past(reg_addr_in) == pss_pkg::REG_ADDR[pss_pkg::RI_POS] |-> reg_rdata_out == {4'h0, $past(q.pos)})
    else $error("position read mismatch");

  slot_len_a: assert property ( // RL2
    $rose(q.state == pss_pkg::SEQ_RUN) && occ(q.pos) |-> q.slot_left == pss_pkg::SLOT_US[slot_len])
    else $error("occupied slot time wrong");

  empty_len_a: assert property ( // RL3
    $rose(q.state == pss_pkg::SEQ_RUN) && !occ(q.pos) |-> q.slot_left == pss_pkg::SLOT_US[empty_wait])
    else $error("empty slot time wrong");

  lin_act_a: assert property ( // RL4
    q.pos > $past(q.pos) |-> (lin_hit & ~power_out.lin) == 4'h0)
    else $error("linear regulator missed its slot");

  sw_act_a: assert property ( // RL5
    q.pos > $past(q.pos) |-> (sw_hit & ~power_out.sw) == 4'h0)
    else $error("switcher missed its slot");

  out_on_a: assert property ( // RL6
    $changed(q.pos) |-> (oa_hit & ~od_hit & ~power_out.gpo) == 5'h00)
    else $error("output not asserted at slot");

  out_off_a: assert property ( // RL7
    $changed(q.pos) |-> (od_hit & power_out.gpo) == 5'h00)
    else $error("output not released at slot");

  pd_clk_a: assert property ( // RL8 RL9
    q.pos > $past(q.pos) |-> (pd_slot != q.pos || power_out.pulldown_disable) && (clk_slot != q.pos || power_out.clk32))
    else $error("pull-down or clock action missed");

  hold_slot_a: assert property ( // RL10
    q.state == pss_pkg::SEQ_HOLD |-> q.pos == wait_slot && ($past(q.state) != pss_pkg::SEQ_HOLD || $stable(q.pos)))
    else $error("hold away from wait slot");

  hold_dir_a: assert property ( // RL15
    $rose(q.state == pss_pkg::SEQ_HOLD) |-> (q.pos > $past(q.pos) ? wdir[pss_pkg::WDIR_UP] : wdir[pss_pkg::WDIR_DN]))
    else $error("hold in disallowed direction");

  step_one_a: assert property ( // RL16
    $changed(q.pos) |-> $past(expire) && (q.pos == 4'($past(q.pos) + 4'h1) || q.pos == 4'($past(q.pos) - 4'h1)))
    else $error("position jumped");

  floor_a: assert property ( // RL17
    q.pos < $past(q.pos) |-> q.pos >= stop_slot ##1 q.pos >= stop_slot || $changed(stop_slot))
    else $error("went below standby stop slot");

  // ==========================================================================
  // Domain ends, direction and hold
  // Bad bound order is software's fault, so the system, power and power1 end checks only cover ends at or above the standby stop slot

  end_any_a: assert property ( // RL17
    $fell(busy_out) |-> q.pos == $past(tgt))
    else $error("sequence stopped off target");

  end_standby_a: assert property ( // RL13
    $fell(busy_out) && pss_pkg::pss_dom_e'($past(target_in)) == pss_pkg::DOM_STANDBY
    |-> q.pos == $past(stop_slot))
    else $error("standby stop slot missed");

  end_system_a: assert property ( // RL12
    $fell(busy_out) && pss_pkg::pss_dom_e'($past(target_in)) == pss_pkg::DOM_SYSTEM && $past(sys_end >= stop_slot)
    |-> q.pos == $past(sys_end))
    else $error("system domain end missed");

  end_power_a: assert property ( // RL11
    $fell(busy_out) && pss_pkg::pss_dom_e'($past(target_in)) == pss_pkg::DOM_POWER && $past(pwr_end >= stop_slot)
    |-> q.pos == $past(pwr_end))
    else $error("power domain end missed");

  end_power1_a: assert property ( // RL14
    $fell(busy_out) && pss_pkg::pss_dom_e'($past(target_in)) == pss_pkg::DOM_POWER1 && $past(max_slot >= stop_slot)
    |-> q.pos == $past(max_slot))
    else $error("maximum slot missed");

  step_dir_a: assert property ( // RL17
    $changed(q.pos) |-> (q.pos > $past(q.pos)) == ($past(tgt) > $past(q.pos)))
    else $error("stepped away from target");

  pos_still_a: assert property ( // RL16
    $past(q.state) != pss_pkg::SEQ_RUN |-> $stable(q.pos))
    else $error("position moved outside a slot");

  outs_still_a: assert property ( // RL16
    $stable(q.pos) |-> $stable(power_out))
    else $error("resource changed without a step");

  down_off_a: assert property ( // RL4 RL5
    q.pos < $past(q.pos) |-> (power_out.lin & $past(lin_hit)) == 4'h0 && (power_out.sw & $past(sw_hit)) == 4'h0)
    else $error("regulator left on below its slot");

  up_keep_a: assert property ( // RL4 RL5
    q.pos > $past(q.pos)
    |-> ($past(power_out.lin) & ~power_out.lin) == 4'h0 && ($past(power_out.sw) & ~power_out.sw) == 4'h0)
    else $error("regulator dropped while going up");

  down_pd_clk_a: assert property ( // RL8 RL9
    q.pos < $past(q.pos)
    |-> !(power_out.pulldown_disable && $past(pd_slot == q.pos)) && !(power_out.clk32 && $past(clk_slot == q.pos)))
    else $error("pull-down or clock left on below its slot");

  reg_write_a: assert property ( // RL2
    $past(reg_wr_in) && $past(reg_addr_in) == pss_pkg::REG_ADDR[pss_pkg::RI_TIM]
    |-> q.regs[pss_pkg::RI_TIM] == $past(reg_wdata_in))
    else $error("slot timing write lost");

  bound_read_a: assert property ( // RL11 RL12
    $past(reg_addr_in) == pss_pkg::REG_ADDR[pss_pkg::RI_DOM_A]
    |-> reg_rdata_out == $past(q.regs[pss_pkg::RI_DOM_A]))
    else $error("domain bound read mismatch");

  hold_stay_a: assert property ( // RL10
    q.state == pss_pkg::SEQ_HOLD && !q.sync[1] |=> q.state == pss_pkg::SEQ_HOLD)
    else $error("left wait slot without release");

  hold_leave_a: assert property ( // RL10
    q.state == pss_pkg::SEQ_HOLD && q.sync[1] |=> q.state != pss_pkg::SEQ_HOLD)
    else $error("release ignored at wait slot");

endmodule

// ===== verif/pss_partner.sv
// Far-side model: external supply that releases the sequencer wait slot
`timescale 1ns/1ps
module pss_partner #(
  parameter int DLY = 5
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Sequencer side
  input wire pss_pkg::pss_pwr_s power_in,
  input wire logic release_en_in,
  output logic wait_release_out
);
  int cnt;

  // Ready only while a switcher feeds the supply, after a settling delay
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 0;
      wait_release_out <= 1'b0;
    end else if (!release_en_in || power_in.sw == 4'h0) begin
      cnt <= 0;
      wait_release_out <= 1'b0;
    end else begin
      if (cnt < DLY) begin
        cnt <= cnt + 1;
      end
      wait_release_out <= (cnt >= DLY);
    end
  end
endmodule

// ===== verif/pss_seq_tb.sv
// Self-checking bench of the slot power sequencer
`timescale 1ns/1ps
module pss_seq_tb;
  localparam int US = 1;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h81;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [1:0] target_in = 2'h0;
  logic rel_en = 1'b0;
  logic wait_release;
  logic [7:0] reg_rdata_out;
  pss_pkg::pss_pwr_s power_out;
  logic busy_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Slot 1 lin0, slot 2 sw0 and out0 on, slot 3 clock and pull-down, slot 4 out0 off
  logic [15:0] cfg [14] = '{16'h8210, 16'h8351, 16'h8455, 16'h8830, 16'h8952, 16'h8A55, 16'h8D42,
    16'h8E55, 16'h8F55, 16'h9055, 16'h9155, 16'h9230, 16'h9532, 16'h9614};

  always #20 core_clk_in = ~core_clk_in;

  pss_seq #(.US_CYC_P(US)) u_dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .target_in(target_in), .wait_release_in(wait_release),
    .power_out(power_out), .busy_out(busy_out));
  pss_partner #(.DLY(5)) u_far (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .power_in(power_out), .release_en_in(rel_en), .wait_release_out(wait_release));

  // ==========================================================================
  // Checks and bus tasks
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(string nm, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic chk_pwr(pss_pkg::pss_pwr_s exp);
    samples_checked++;
    if (power_out !== exp) begin
      n_mismatch++;
      $display("MISMATCH power exp %h got %h", exp, power_out);
    end
  endtask

  task automatic chk_cnt(string nm, int lo, int hi, int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask

  function automatic pss_pkg::pss_pwr_s mk(logic [3:0] l, logic [3:0] s, logic [4:0] g, logic p, logic c);
    return {l, s, g, p, c};
  endfunction

  function automatic int cyc(int c);
    return int'(pss_pkg::SLOT_US[c]) * US;
  endfunction

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wr_in <= 1'b1;
    reg_wdata_in <= v;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_addr_in <= 8'h81;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_addr_in <= 8'h81;
    #1;
    d = reg_rdata_out;
  endtask

  // Position is watched through the read port, left at 0x81 between accesses
  task automatic wait_pos(logic [3:0] p, int lim, output int n);
    n = 0;
    while (reg_rdata_out !== {4'h0, p}) begin
      @(posedge core_clk_in);
      #1;
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("MISMATCH position exp %h got %h", p, reg_rdata_out);
        results();
      end
    end
  endtask

  // Start from idle adds a little, so the window is a few cycles wide
  task automatic step(logic [1:0] t, logic [3:0] p, int c);
    int n;
    @(posedge core_clk_in);
    target_in <= t;
    wait_pos(p, 9000, n);
    chk_cnt("slot cycles", cyc(c), cyc(c) + 3, n);
  endtask

  task automatic do_reset();
    @(posedge core_clk_in);
    arst_n_in <= 1'b0;
    target_in <= 2'h0;
    rel_en <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_regs();
    logic [7:0] d;
    for (int i = 0; i < pss_pkg::NREG; i++) begin
      rd(pss_pkg::REG_ADDR[i], d);
      chk_reg("reset value", 8'h00, d);
    end
    wr(8'h81, 8'hFF);
    rd(8'h81, d);
    chk_reg("position", 8'h00, d);
    wr(8'h85, 8'h5A);
    rd(8'h85, d);
    chk_reg("unmapped", 8'h00, d);
    for (int i = 1; i < pss_pkg::NREG; i++) begin
      wr(pss_pkg::REG_ADDR[i], 8'hC3 ^ 8'(i));
      rd(pss_pkg::REG_ADDR[i], d);
      chk_reg("readback", 8'hC3 ^ 8'(i), d);
    end
    $display("test regs done");
  endtask

  task automatic test_up_down();
    int n;
    foreach (cfg[i]) wr(cfg[i][15:8], cfg[i][7:0]);
    wait_pos(4'h1, 300, n);
    chk_cnt("first slot", cyc(1), cyc(1) + 3, n);
    chk_pwr(mk(4'h1, 4'h0, 5'h00, 1'b0, 1'b0));
    step(2'h1, 4'h2, 0);
    chk_pwr(mk(4'h1, 4'h1, 5'h01, 1'b0, 1'b0));
    repeat (60) @(posedge core_clk_in);
    #1;
    chk_reg("system stop", 8'h02, reg_rdata_out);
    step(2'h3, 4'h3, 0);
    chk_pwr(mk(4'h1, 4'h1, 5'h01, 1'b1, 1'b1));
    wait_pos(4'h4, 300, n);
    chk_cnt("empty slot", cyc(1), cyc(1), n);
    chk_pwr(mk(4'h1, 4'h1, 5'h00, 1'b1, 1'b1));
    step(2'h0, 4'h3, 1);
    chk_pwr(mk(4'h1, 4'h1, 5'h00, 1'b1, 1'b1));
    wait_pos(4'h2, 300, n);
    chk_cnt("down empty", cyc(1), cyc(1), n);
    chk_pwr(mk(4'h1, 4'h1, 5'h01, 1'b0, 1'b0));
    wait_pos(4'h1, 300, n);
    chk_cnt("down slot", cyc(0), cyc(0), n);
    chk_pwr(mk(4'h1, 4'h0, 5'h01, 1'b0, 1'b0));
    repeat (100) @(posedge core_clk_in);
    #1;
    chk_reg("standby stop", 8'h01, reg_rdata_out);
    chk_reg("busy idle", 8'h00, 8'(busy_out));
    $display("test up down done");
  endtask

  // Power end 3 sits between system end 2 and maximum 4; codes sweep left a long slot
  task automatic test_power();
    int n;
    wr(8'h82, 8'h10);
    step(2'h1, 4'h2, 0);
    step(2'h2, 4'h3, 0);
    repeat (80) @(posedge core_clk_in);
    #1;
    chk_reg("power stop", 8'h03, reg_rdata_out);
    chk_pwr(mk(4'h1, 4'h1, 5'h01, 1'b1, 1'b1));
    @(posedge core_clk_in);
    target_in <= 2'h0;
    wait_pos(4'h1, 300, n);
    chk_cnt("power down", cyc(1) + cyc(0), cyc(1) + cyc(0) + 3, n);
    chk_pwr(mk(4'h1, 4'h0, 5'h01, 1'b0, 1'b0));
    $display("test power done");
  endtask

  task automatic test_codes();
    for (int c = 0; c < 16; c++) begin
      wr(8'h82, {4'h1, 4'(c)});
      step(2'h1, 4'h2, c);
      step(2'h0, 4'h1, c);
    end
    $display("test codes done");
  endtask

  // Probe after 80 cycles: past one empty slot, short of the next one
  task automatic hold(logic h, logic [3:0] nx);
    int n;
    wait_pos(4'h3, 300, n);
    repeat (80) @(posedge core_clk_in);
    #1;
    chk_reg("wait hold", h ? 8'h03 : {4'h0, nx}, reg_rdata_out);
    if (h) begin
      chk_reg("busy in hold", 8'h01, 8'(busy_out));
    end
    @(posedge core_clk_in);
    rel_en <= 1'b1;
    wait_pos(nx, 300, n);
    @(posedge core_clk_in);
    rel_en <= 1'b0;
  endtask

  task automatic test_wait();
    int n;
    wr(8'h92, 8'h33);
    for (int d = 0; d < 4; d++) begin
      wr(8'h97, {2'(d), 6'h00});
      @(posedge core_clk_in);
      target_in <= 2'h3;
      hold(d[0], 4'h4);
      @(posedge core_clk_in);
      target_in <= 2'h0;
      hold(d[1], 4'h2);
      wait_pos(4'h1, 300, n);
    end
    $display("test wait done");
  endtask

  initial begin
    do_reset();
    test_regs();
    do_reset();
    test_up_down();
    test_codes();
    test_power();
    test_wait();
    results();
  end
endmodule
